// File: cidec_regs.svh
// opcode values, atomic count, stack step and flag positions for the instruction decode subset
// assumes: included by the package and the decoder; definitions only
`ifndef CIDEC_REGS_SVH
`define CIDEC_REGS_SVH
`define CIDEC_OP_BRK        8'h00
`define CIDEC_OP_ATOMIC     8'h2F
`define CIDEC_OP_AND_LO     8'h52
`define CIDEC_OP_AND_HI     8'h57
`define CIDEC_OP_AND_EXTENDED_ER    8'h58
`define CIDEC_OP_AND_EXTENDED_IM    8'h59
`define CIDEC_OP_CALL_IRR   8'hD4
`define CIDEC_OP_REVERSE    8'hD5
`define CIDEC_OP_CALL_DA    8'hD6
`define CIDEC_OP_BITOP      8'hE2
`define CIDEC_OP_BTJ_R      8'hF6
`define CIDEC_OP_BTJ_IR     8'hF7
`define CIDEC_OP_TM         8'h72
`define CIDEC_OP_TCM        8'h62
`define CIDEC_OP_TMX        8'h78
`define CIDEC_OP_TEST_COMPLEMENT_MASK_EXTENDED       8'h68
`define CIDEC_OP_CONSTANT_BLOCK_TRANSFER       8'hC3
`define CIDEC_OP_EXTERNAL_BLOCK_TRANSFER       8'h83
`define CIDEC_ATOMIC_COUNT  2'd3
`define CIDEC_SP_STEP       16'h0002
// flag vector positions: c z s v d h
`define CIDEC_FLAG_C        5
`define CIDEC_FLAG_Z        4
`define CIDEC_FLAG_S        3
`define CIDEC_FLAG_V        2
`define CIDEC_FLAG_D        1
`define CIDEC_FLAG_H        0
`endif

// File: cidec_pkg.sv
// types shared by the decoder and its timing table
// assumes: cidec_regs.svh is on the include path
`include "cidec_regs.svh"
package cidec_pkg;
  typedef enum logic [2:0] {
    CIDEC_ST_IDLE  = 3'b000,
    CIDEC_ST_FETCH = 3'b001,
    CIDEC_ST_EXEC  = 3'b011,
    CIDEC_ST_DONE  = 3'b010
  } cidec_state_type;

  typedef enum logic [3:0] {
    CIDEC_K_NONE, CIDEC_K_AND, CIDEC_K_ATOMIC, CIDEC_K_BITOP, CIDEC_K_BRK,
    CIDEC_K_REVERSE, CIDEC_K_BTJ, CIDEC_K_CALL, CIDEC_K_TM, CIDEC_K_TCM,
    CIDEC_K_CONSTANT_BLOCK_TRANSFER, CIDEC_K_EXTERNAL_BLOCK_TRANSFER
  } cidec_kind_type;

  typedef enum logic [2:0] {
    CIDEC_AM_REG, CIDEC_AM_IREG, CIDEC_AM_FULL, CIDEC_AM_IFULL, CIDEC_AM_IMM,
    CIDEC_AM_EXT, CIDEC_AM_DA, CIDEC_AM_IRR
  } cidec_mode_type;
endpackage

// File: cidec_timing.sv
// opcode classifier: kind, operand modes and fetch/exec cycle counts
// assumes: purely combinational, fed by the registered opcode byte
`timescale 1ns/1ps
`include "cidec_regs.svh"
module cidec_timing (
  input  wire logic [7:0]              opcode,
  output cidec_pkg::cidec_kind_type    kind,
  output cidec_pkg::cidec_mode_type    dst_mode,
  output cidec_pkg::cidec_mode_type    src_mode,
  output logic [2:0]                   fetch_cycles,
  output logic [2:0]                   exec_cycles
);
  // addressing mode comes from the primary opcode only
  always_comb begin
    kind         = cidec_pkg::CIDEC_K_NONE;
    dst_mode     = cidec_pkg::CIDEC_AM_REG;
    src_mode     = cidec_pkg::CIDEC_AM_REG;
    fetch_cycles = 3'd1;
    exec_cycles  = 3'd1;
    case (opcode)
      `CIDEC_OP_BRK: begin
        kind = cidec_pkg::CIDEC_K_BRK;
      end
      `CIDEC_OP_ATOMIC: begin
        kind        = cidec_pkg::CIDEC_K_ATOMIC;
        exec_cycles = 3'd2;
      end
      8'h52: begin
        kind = cidec_pkg::CIDEC_K_AND; fetch_cycles = 3'd2; exec_cycles = 3'd3;
      end
      8'h53: begin
        kind = cidec_pkg::CIDEC_K_AND; src_mode = cidec_pkg::CIDEC_AM_IREG;
        fetch_cycles = 3'd2; exec_cycles = 3'd4;
      end
      8'h54: begin
        kind = cidec_pkg::CIDEC_K_AND; dst_mode = cidec_pkg::CIDEC_AM_FULL;
        src_mode = cidec_pkg::CIDEC_AM_FULL; fetch_cycles = 3'd3; exec_cycles = 3'd3;
      end
      8'h55: begin
        kind = cidec_pkg::CIDEC_K_AND; dst_mode = cidec_pkg::CIDEC_AM_FULL;
        src_mode = cidec_pkg::CIDEC_AM_IFULL; fetch_cycles = 3'd3; exec_cycles = 3'd4;
      end
      8'h56: begin
        kind = cidec_pkg::CIDEC_K_AND; dst_mode = cidec_pkg::CIDEC_AM_FULL;
        src_mode = cidec_pkg::CIDEC_AM_IMM; fetch_cycles = 3'd3; exec_cycles = 3'd3;
      end
      `CIDEC_OP_AND_HI: begin
        kind = cidec_pkg::CIDEC_K_AND; dst_mode = cidec_pkg::CIDEC_AM_IFULL;
        src_mode = cidec_pkg::CIDEC_AM_IMM; fetch_cycles = 3'd3; exec_cycles = 3'd4;
      end
      `CIDEC_OP_AND_EXTENDED_ER: begin
        kind = cidec_pkg::CIDEC_K_AND; dst_mode = cidec_pkg::CIDEC_AM_EXT;
        src_mode = cidec_pkg::CIDEC_AM_EXT; fetch_cycles = 3'd4; exec_cycles = 3'd3;
      end
      `CIDEC_OP_AND_EXTENDED_IM: begin
        kind = cidec_pkg::CIDEC_K_AND; dst_mode = cidec_pkg::CIDEC_AM_EXT;
        src_mode = cidec_pkg::CIDEC_AM_IMM; fetch_cycles = 3'd4; exec_cycles = 3'd3;
      end
      `CIDEC_OP_BITOP: begin
        kind = cidec_pkg::CIDEC_K_BITOP; fetch_cycles = 3'd2; exec_cycles = 3'd2;
      end
      `CIDEC_OP_REVERSE: begin
        kind = cidec_pkg::CIDEC_K_REVERSE; dst_mode = cidec_pkg::CIDEC_AM_FULL;
        fetch_cycles = 3'd2; exec_cycles = 3'd2;
      end
      `CIDEC_OP_BTJ_R: begin
        kind = cidec_pkg::CIDEC_K_BTJ; fetch_cycles = 3'd3; exec_cycles = 3'd3;
      end
      `CIDEC_OP_BTJ_IR: begin
        kind = cidec_pkg::CIDEC_K_BTJ; src_mode = cidec_pkg::CIDEC_AM_IREG;
        fetch_cycles = 3'd3; exec_cycles = 3'd4;
      end
      `CIDEC_OP_CALL_IRR: begin
        kind = cidec_pkg::CIDEC_K_CALL; dst_mode = cidec_pkg::CIDEC_AM_IRR;
        fetch_cycles = 3'd2; exec_cycles = 3'd6;
      end
      `CIDEC_OP_CALL_DA: begin
        kind = cidec_pkg::CIDEC_K_CALL; dst_mode = cidec_pkg::CIDEC_AM_DA;
        fetch_cycles = 3'd3; exec_cycles = 3'd3;
      end
      `CIDEC_OP_TM, `CIDEC_OP_TCM: begin
        kind = (opcode == `CIDEC_OP_TM) ? cidec_pkg::CIDEC_K_TM : cidec_pkg::CIDEC_K_TCM;
        fetch_cycles = 3'd2; exec_cycles = 3'd3;
      end
      `CIDEC_OP_TMX, `CIDEC_OP_TEST_COMPLEMENT_MASK_EXTENDED: begin
        kind = (opcode == `CIDEC_OP_TMX) ? cidec_pkg::CIDEC_K_TM : cidec_pkg::CIDEC_K_TCM;
        dst_mode = cidec_pkg::CIDEC_AM_EXT; src_mode = cidec_pkg::CIDEC_AM_EXT;
        fetch_cycles = 3'd4; exec_cycles = 3'd3;
      end
      `CIDEC_OP_CONSTANT_BLOCK_TRANSFER: begin
        kind = cidec_pkg::CIDEC_K_CONSTANT_BLOCK_TRANSFER; src_mode = cidec_pkg::CIDEC_AM_IREG;
        fetch_cycles = 3'd2; exec_cycles = 3'd5;
      end
      `CIDEC_OP_EXTERNAL_BLOCK_TRANSFER: begin
        kind = cidec_pkg::CIDEC_K_EXTERNAL_BLOCK_TRANSFER; src_mode = cidec_pkg::CIDEC_AM_IREG;
        fetch_cycles = 3'd2; exec_cycles = 3'd5;
      end
      default: begin
        kind = cidec_pkg::CIDEC_K_NONE;
      end
    endcase
  end
endmodule

// File: cidec_core.sv
// decode and execute for a subset of the 8-bit cpu instruction set
// assumes: instruction bytes arrive on a same-clock strobe, operands are
// supplied by the surrounding datapath already read from the register file
//
// Contract
// - atomic prefix blocks interrupt/DMA for next three instructions; 1 fetch, 2 exec, no flags
// - AND source into destination, opcodes 52..57 select operand forms
// - extended AND 58/59, four fetches; Z,S from result, V cleared, rest kept
// - E2 bit clear/set/assign, 2 fetch 2 exec; set/assign clear V
// - opcode 00 is debugger break, one fetch one exec, no flags
// - D5 reverses full-register bits; C undefined, Z,S from result, V cleared
// - bit test jump adds offset to PC when source bit equals polarity
// - jump-if-set and jump-if-clear are the same encodings with fixed polarity
// - call: SP minus two, push PC, load destination; D4 and D6 forms
// - test under mask and complement under mask, register and extended forms
// - constant block transfer moves byte then increments both addresses
// - external block transfer moves data byte then increments both addresses
// - flag columns: result-derived, unaffected, undefined, cleared or set
`timescale 1ns/1ps
`include "cidec_regs.svh"
module cidec_core (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_data,
  input  wire logic [7:0]  dst_value,
  input  wire logic [7:0]  src_value,
  input  wire logic [15:0] pc_in,
  input  wire logic [15:0] sp_in,
  input  wire logic [15:0] call_target,
  input  wire logic [11:0] mem_addr_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [5:0]  flags_in,
  output logic             busy,
  output logic             instr_done,
  output logic [7:0]       opcode_out,
  output logic [7:0]       result_q,
  output logic             result_we_q,
  output logic [5:0]       flags_q,
  output logic [15:0]      pc_q,
  output logic             pc_we_q,
  output logic [15:0]      sp_q,
  output logic             push_we_q,
  output logic [11:0]      mem_addr_q,
  output logic [7:0]       reg_addr_q,
  output logic             break_q,
  output logic             irq_block
);
  cidec_pkg::cidec_state_type state_q, state_d;
  cidec_pkg::cidec_kind_type  kind;
  cidec_pkg::cidec_mode_type  dst_mode, src_mode;
  logic [2:0]  fetch_cycles, exec_cycles;
  logic [7:0]  op_q, op_d, b2_q, b2_d, b3_q, b3_d;
  logic [2:0]  cnt_q, cnt_d;
  logic [1:0]  atom_q, atom_d;
  logic [7:0]  result_d;
  logic        result_we_d, pc_we_d, push_we_d, break_d;
  logic [5:0]  flags_d;
  logic [15:0] pc_d, sp_d;
  logic [11:0] mem_addr_d;
  logic [7:0]  reg_addr_d;
  logic [7:0]  and_res, bit_res, rev_res, mask_res;
  logic [2:0]  bit_sel;
  logic        pol;

  cidec_timing u_timing (
    .opcode       (op_q),
    .kind         (kind),
    .dst_mode     (dst_mode),
    .src_mode     (src_mode),
    .fetch_cycles (fetch_cycles),
    .exec_cycles  (exec_cycles)
  );

  // second byte: bit 7 polarity, bits 6:4 bit index
  assign bit_sel = b2_q[6:4];
  assign pol     = b2_q[7];
  assign and_res = dst_value & src_value;
  assign mask_res = (kind == cidec_pkg::CIDEC_K_TCM) ? (~dst_value & src_value) : (dst_value & src_value);

  always_comb begin
    rev_res = 8'h00;
    for (int i = 0; i < 8; i++) begin
      rev_res[i] = dst_value[7 - i];
    end
    bit_res = dst_value;
    bit_res[bit_sel] = pol;
  end

  always_comb begin
    state_d     = state_q;
    op_d        = op_q;
    b2_d        = b2_q;
    b3_d        = b3_q;
    cnt_d       = cnt_q;
    atom_d      = atom_q;
    result_d    = result_q;
    result_we_d = 1'b0;
    flags_d     = flags_q;
    pc_d        = pc_q;
    pc_we_d     = 1'b0;
    sp_d        = sp_q;
    push_we_d   = 1'b0;
    mem_addr_d  = mem_addr_q;
    reg_addr_d  = reg_addr_q;
    break_d     = 1'b0;
    case (state_q)
      cidec_pkg::CIDEC_ST_IDLE: begin
        if (byte_valid) begin
          op_d    = byte_data;
          cnt_d   = 3'd1;
          state_d = cidec_pkg::CIDEC_ST_FETCH;
        end
      end
      cidec_pkg::CIDEC_ST_FETCH: begin
        if (cnt_q >= fetch_cycles) begin
          cnt_d   = 3'd1;
          state_d = cidec_pkg::CIDEC_ST_EXEC;
        end else if (byte_valid) begin
          // only bytes two and three carry fields; a fourth operand byte is dropped
          if (cnt_q == 3'd1) begin
            b2_d = byte_data;
          end else if (cnt_q == 3'd2) begin
            b3_d = byte_data;
          end
          cnt_d = cnt_q + 3'd1;
        end
      end
      cidec_pkg::CIDEC_ST_EXEC: begin
        if (cnt_q < exec_cycles) begin
          cnt_d = cnt_q + 3'd1;
        end else begin
          state_d = cidec_pkg::CIDEC_ST_DONE;
          flags_d = flags_in;
          case (kind)
            cidec_pkg::CIDEC_K_AND: begin
              result_d = and_res;
              result_we_d = 1'b1;
              flags_d[`CIDEC_FLAG_Z] = (and_res == 8'h00);
              flags_d[`CIDEC_FLAG_S] = and_res[7];
              flags_d[`CIDEC_FLAG_V] = 1'b0;
            end
            cidec_pkg::CIDEC_K_ATOMIC: begin
              atom_d = `CIDEC_ATOMIC_COUNT;
            end
            cidec_pkg::CIDEC_K_BITOP: begin
              result_d = bit_res;
              result_we_d = 1'b1;
              // polarity 0 is bit clear and changes no flag
              if (pol) begin
                flags_d[`CIDEC_FLAG_V] = 1'b0;
              end
            end
            cidec_pkg::CIDEC_K_BRK: begin
              break_d = 1'b1;
            end
            cidec_pkg::CIDEC_K_REVERSE: begin
              result_d = rev_res;
              result_we_d = 1'b1;
              // carry is undefined; it is left as it was
              flags_d[`CIDEC_FLAG_Z] = (rev_res == 8'h00);
              flags_d[`CIDEC_FLAG_S] = rev_res[7];
              flags_d[`CIDEC_FLAG_V] = 1'b0;
            end
            cidec_pkg::CIDEC_K_BTJ: begin
              // fixed-polarity forms just encode pol as 1 or 0
              if (src_value[bit_sel] == pol) begin
                pc_d = pc_in + {{8{b3_q[7]}}, b3_q};
                pc_we_d = 1'b1;
              end
            end
            cidec_pkg::CIDEC_K_CALL: begin
              sp_d = sp_in - `CIDEC_SP_STEP;
              push_we_d = 1'b1;
              pc_d = call_target;
              pc_we_d = 1'b1;
            end
            cidec_pkg::CIDEC_K_TM, cidec_pkg::CIDEC_K_TCM: begin
              flags_d[`CIDEC_FLAG_Z] = (mask_res == 8'h00);
              flags_d[`CIDEC_FLAG_S] = mask_res[7];
              flags_d[`CIDEC_FLAG_V] = 1'b0;
            end
            cidec_pkg::CIDEC_K_CONSTANT_BLOCK_TRANSFER, cidec_pkg::CIDEC_K_EXTERNAL_BLOCK_TRANSFER: begin
              result_d = src_value;
              result_we_d = 1'b1;
              mem_addr_d = mem_addr_in + 12'h001;
              reg_addr_d = reg_addr_in + 8'h01;
            end
            default: begin
              flags_d = flags_in;
            end
          endcase
          // the prefix itself does not count toward the three guarded
          if (kind != cidec_pkg::CIDEC_K_ATOMIC && atom_q != 2'd0) begin
            atom_d = atom_q - 2'd1;
          end
        end
      end
      cidec_pkg::CIDEC_ST_DONE: begin
        state_d = cidec_pkg::CIDEC_ST_IDLE;
      end
      default: begin
        state_d = cidec_pkg::CIDEC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q     <= cidec_pkg::CIDEC_ST_IDLE;
      op_q        <= 8'h00;
      b2_q        <= 8'h00;
      b3_q        <= 8'h00;
      cnt_q       <= 3'd0;
      atom_q      <= 2'd0;
      result_q    <= 8'h00;
      result_we_q <= 1'b0;
      flags_q     <= 6'h00;
      pc_q        <= 16'h0000;
      pc_we_q     <= 1'b0;
      sp_q        <= 16'h0000;
      push_we_q   <= 1'b0;
      mem_addr_q  <= 12'h000;
      reg_addr_q  <= 8'h00;
      break_q     <= 1'b0;
    end else begin
      state_q     <= state_d;
      op_q        <= op_d;
      b2_q        <= b2_d;
      b3_q        <= b3_d;
      cnt_q       <= cnt_d;
      atom_q      <= atom_d;
      result_q    <= result_d;
      result_we_q <= result_we_d;
      flags_q     <= flags_d;
      pc_q        <= pc_d;
      pc_we_q     <= pc_we_d;
      sp_q        <= sp_d;
      push_we_q   <= push_we_d;
      mem_addr_q  <= mem_addr_d;
      reg_addr_q  <= reg_addr_d;
      break_q     <= break_d;
    end
  end

  assign busy       = (state_q != cidec_pkg::CIDEC_ST_IDLE);
  assign instr_done = (state_q == cidec_pkg::CIDEC_ST_DONE);
  assign opcode_out = op_q;
  // held from the end of the prefix until three more instructions retire
  assign irq_block  = (atom_q != 2'd0);
endmodule

// File: cidec_core_asserts.sv
// checker for the decode subset core, bound to every cidec_core
// assumes: the driver holds operand, flag and stack inputs until the instruction is done
`timescale 1ns/1ps
module cidec_core_asserts (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic [7:0]  dst_value,
  input wire logic [5:0]  flags_in,
  input wire logic [15:0] sp_in,
  input wire logic [15:0] call_target,
  input wire logic        busy,
  input wire logic        instr_done,
  input wire logic [7:0]  opcode_out,
  input wire logic [7:0]  result_q,
  input wire logic        result_we_q,
  input wire logic [5:0]  flags_q,
  input wire logic [15:0] pc_q,
  input wire logic        pc_we_q,
  input wire logic [15:0] sp_q,
  input wire logic        push_we_q,
  input wire logic        break_q,
  input wire logic        irq_block
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [7:0] rev_w;
  logic       and_w;
  assign rev_w = {<<{dst_value}};
  assign and_w = opcode_out inside {[8'h52:8'h59]};
  a_done_single: assert property (instr_done |=> !instr_done && !busy)
    else $error("done not followed by idle");
  a_pulse_done: assert property ((result_we_q || pc_we_q || push_we_q || break_q) |-> instr_done)
    else $error("write pulse outside done");
  a_break_op: assert property (break_q |-> opcode_out == 8'h00)
    else $error("break pulse on other opcode");
  a_break_flags: assert property (instr_done && opcode_out == 8'h00 |-> break_q && flags_q == flags_in)
    else $error("break changed flags or gave no pulse");
  a_call_stack: assert property (push_we_q |-> sp_q == sp_in - 16'h0002 && pc_we_q && pc_q == call_target)
    else $error("call stack or target wrong");
  a_and_flags: assert property (instr_done && and_w |-> !flags_q[2] && flags_q[4] == (result_q == 8'h00)
    && flags_q[3] == result_q[7] && flags_q[5] == flags_in[5])
    else $error("and flags wrong");
  a_reverse_bits: assert property (instr_done && opcode_out == 8'hD5 |-> result_we_q && result_q == rev_w)
    else $error("bit reverse wrong");
  a_atomic_block: assert property (instr_done && opcode_out == 8'h2F |-> irq_block && flags_q == flags_in)
    else $error("atomic prefix did not block");
  a_mask_flags: assert property (instr_done && opcode_out inside {8'h72, 8'h62, 8'h78, 8'h68} |-> !flags_q[2]
    && !result_we_q && flags_q[5] == flags_in[5] && flags_q[1:0] == flags_in[1:0])
    else $error("test under mask flags wrong");
  a_jump_flags: assert property (instr_done && opcode_out inside {8'hF6, 8'hF7} |-> flags_q == flags_in
    && !result_we_q)
    else $error("bit test jump touched flags");
endmodule
bind cidec_core cidec_core_asserts u_chk (.clk_sys, .reset, .dst_value, .flags_in, .sp_in, .call_target, .busy,
  .instr_done, .opcode_out, .result_q, .result_we_q, .flags_q, .pc_q, .pc_we_q, .sp_q, .push_we_q, .break_q,
  .irq_block);

// File: cidec_progmem.sv
// program memory model: streams one four-byte instruction per start
// assumes: start is a one-cycle request driven just after a rising edge
`timescale 1ns/1ps
module cidec_progmem (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic [31:0] instr,
  output logic             byte_valid,
  output logic [7:0]       byte_data
);
  logic [31:0] sh_q;
  logic [2:0]  cnt_q;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sh_q <= 32'h0;
      cnt_q <= 3'h0;
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
    end else if (start) begin
      sh_q <= instr << 8;
      cnt_q <= 3'h3;
      byte_valid <= 1'b1;
      byte_data <= instr[31:24];
    end else if (cnt_q != 3'h0) begin
      sh_q <= sh_q << 8;
      cnt_q <= cnt_q - 3'h1;
      byte_data <= sh_q[31:24];
    end else begin
      // released bus toggles so a stale byte can never look valid
      byte_valid <= 1'b0;
      byte_data <= ~byte_data;
    end
  end
endmodule

// File: cidec_core_bench.sv
// self-checking bench for cidec_core with a program memory model
// assumes: cidec_core, cidec_progmem and the bound checker are compiled first
`timescale 1ns/1ps
module cidec_core_bench;
  typedef struct packed {
    logic [7:0]  op;
    logic [7:0]  res;
    logic [5:0]  flg;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [11:0] ma;
    logic [7:0]  ra;
    logic [3:0]  pl;
    logic        cr;
    logic        blk;
    logic        atomic_prefix;
  } cidec_exp_type;
  logic          clk_sys;
  logic          reset = 1'b1;
  logic          start = 1'b0;
  logic [31:0]   instr = 32'h0;
  logic [7:0]    dst_value = 8'h00;
  logic [7:0]    src_value = 8'h00;
  logic [15:0]   pc_in = 16'h0000;
  logic [15:0]   sp_in = 16'h0000;
  logic [15:0]   call_target = 16'h0000;
  logic [11:0]   mem_addr_in = 12'h000;
  logic [7:0]    reg_addr_in = 8'h00;
  logic [5:0]    flags_in = 6'h00;
  logic          byte_valid, busy, instr_done, result_we_q, pc_we_q, push_we_q, break_q, irq_block;
  logic [7:0]    byte_data, opcode_out, result_q, reg_addr_q;
  logic [5:0]    flags_q;
  logic [15:0]   pc_q, sp_q;
  logic [11:0]   mem_addr_q;
  cidec_exp_type exp_q[$];
  int            err_count = 0;
  int            num_checks = 0;
  cidec_progmem u_mem (.clk_sys, .reset, .start, .instr, .byte_valid, .byte_data);
  cidec_core dut (.clk_sys, .reset, .byte_valid, .byte_data, .dst_value, .src_value, .pc_in, .sp_in,
    .call_target, .mem_addr_in, .reg_addr_in, .flags_in, .busy, .instr_done, .opcode_out, .result_q,
    .result_we_q, .flags_q, .pc_q, .pc_we_q, .sp_q, .push_we_q, .mem_addr_q, .reg_addr_q, .break_q, .irq_block);
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  function automatic logic [7:0] r8();
    return 8'($urandom);
  endfunction
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    num_checks++;
    if (got !== ex) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic end_of_test;
    if (err_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic run(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3, input logic [7:0] d,
                     input logic [7:0] s);
    cidec_exp_type e;
    logic [7:0]    r;
    logic [2:0]    ix;
    logic [5:0]    fl;
    logic [15:0]   p, sp, ct;
    logic [11:0]   ma;
    logic [7:0]    ra, m;
    int            n;
    fl = 6'($urandom);
    p = 16'($urandom);
    sp = 16'($urandom);
    ct = 16'($urandom);
    ma = 12'($urandom);
    ra = r8();
    ix = b2[6:4];
    e = '0;
    e.op = op;
    e.flg = fl;
    r = d;
    case (op) inside
      [8'h52:8'h59]: r = d & s;
      8'hE2: r[ix] = b2[7];
      8'hD5: r = {<<{d}};
      default: ;
    endcase
    if (op inside {[8'h52:8'h59], 8'hE2, 8'hD5}) begin
      e.res = r;
      e.cr = 1'b1;
      e.pl = 4'h8;
    end
    if (op inside {[8'h52:8'h59], 8'hD5}) e.flg = {fl[5], r == 8'h00, r[7], 1'b0, fl[1:0]};
    if (op == 8'hE2 && b2[7]) e.flg[2] = 1'b0;
    if (op == 8'h00) e.pl = 4'h1;
    if (op inside {8'hF6, 8'hF7} && s[ix] == b2[7]) begin
      e.pl = 4'h4;
      e.pc = p + {{8{b3[7]}}, b3};
    end
    if (op inside {8'hD4, 8'hD6}) begin
      e.pl = 4'h6;
      e.pc = ct;
      e.sp = sp - 16'h0002;
    end
    e.atomic_prefix = op == 8'h2F;
    // test under mask: plain mask for 72/78, complemented destination for 62/68
    m = (op inside {8'h62, 8'h68}) ? (~d & s) : (d & s);
    if (op inside {8'h72, 8'h62, 8'h78, 8'h68}) e.flg = {fl[5], m == 8'h00, m[7], 1'b0, fl[1:0]};
    e.blk = op inside {8'hC3, 8'h83};
    if (e.blk) begin
      e.res = s;
      e.cr = 1'b1;
      e.pl = 4'h8;
    end
    e.ma = ma + 12'h001;
    e.ra = ra + 8'h01;
    exp_q.push_back(e);
    @(posedge clk_sys);
    dst_value <= d;
    src_value <= s;
    flags_in <= fl;
    pc_in <= p;
    sp_in <= sp;
    call_target <= ct;
    mem_addr_in <= ma;
    reg_addr_in <= ra;
    start <= 1'b1;
    instr <= {op, b2, b3, 8'h00};
    @(posedge clk_sys);
    start <= 1'b0;
    n = 0;
    while (instr_done !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk("instr_done", 16'h0001, 16'(instr_done));
    @(posedge clk_sys);
  endtask
  initial begin
    cidec_exp_type e;
    int            acnt;
    acnt = 0;
    forever begin
      @(negedge clk_sys);
      if (instr_done === 1'b1) begin
        e = exp_q.pop_front();
        chk("opcode_out", 16'(e.op), 16'(opcode_out));
        chk("flags_q", 16'(e.flg), 16'(flags_q));
        chk("pulses", 16'(e.pl), 16'({result_we_q, pc_we_q, push_we_q, break_q}));
        if (e.cr) chk("result_q", 16'(e.res), 16'(result_q));
        if (e.pl[2]) chk("pc_q", e.pc, pc_q);
        if (e.pl[1]) chk("sp_q", e.sp, sp_q);
        if (e.blk) begin
          chk("mem_addr_q", 16'(e.ma), 16'(mem_addr_q));
          chk("reg_addr_q", 16'(e.ra), 16'(reg_addr_q));
        end
        if (e.atomic_prefix) acnt = 3;
        else if (acnt != 0) acnt--;
        @(negedge clk_sys);
        chk("irq_block", 16'(acnt != 0), 16'(irq_block));
      end
    end
  end
  initial begin
    repeat (8000) @(posedge clk_sys);
    err_count++;
    end_of_test;
  end
  initial begin
    void'($urandom(32'h332E));
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 16; i++) run(8'h52 + 8'(i % 8), r8(), r8(), r8(), i < 8 ? r8() : 8'h00);
    for (int j = 0; j < 4; j++) run(8'hE2, {1'(j), 7'($urandom)}, r8(), r8(), r8());
    run(8'h00, r8(), r8(), r8(), r8());
    run(8'hD5, r8(), r8(), r8(), r8());
    run(8'hD5, r8(), r8(), 8'h00, r8());
    for (int j = 0; j < 8; j++) run(j < 4 ? 8'hF6 : 8'hF7, {1'(j), 7'($urandom)}, r8(), r8(),
      j[1] ? 8'hFF : 8'h00);
    run(8'hD4, r8(), r8(), r8(), r8());
    run(8'hD6, r8(), r8(), r8(), r8());
    run(8'h2F, r8(), r8(), r8(), r8());
    for (int j = 0; j < 4; j++) run(8'h54, r8(), r8(), r8(), r8());
    for (int j = 0; j < 8; j++) run(j[1] ? (j[0] ? 8'h68 : 8'h78) : (j[0] ? 8'h62 : 8'h72), r8(), r8(), r8(),
      j[2] ? r8() : 8'h00);
    run(8'hC3, r8(), r8(), r8(), r8());
    run(8'h83, r8(), r8(), r8(), r8());
    run(8'hFF, r8(), r8(), r8(), r8());
    end_of_test;
  end
endmodule
